/* ddg_dsp_model.sv */
// Purpose: DSP external data memory bus model.
// Assumes: Requests change 1 ns after a rising clock edge.
// Notes: An idle bus shows an inverted address.
`timescale 1ns/1ps
`default_nettype none
module ddg_dsp_model (
  input wire logic core_clk_in,
  output ddg_pkg::ddg_bus_s bus_out
);
  initial bus_out = '1;
  // One access is held two cycles, then the bus idles.
  task automatic access(input logic [13:0] a, input logic wr);
    @(posedge core_clk_in) #1;
    bus_out = '{a, 1'b0, wr, ~wr};
    repeat (2) @(posedge core_clk_in);
    #1 bus_out = '{~a, 1'b1, 1'b1, 1'b1};
    repeat (3) @(posedge core_clk_in);
  endtask : access
endmodule : ddg_dsp_model
`default_nettype wire

/* ddg_glue.sv */
// Purpose: Row strobe, column strobe and delayed write strobe generation.
// Assumes: Clock is the DSP clock output; DSP bus inputs are synchronised.
// Notes: Row cycle sequencing and refresh timing are kept by DSP software.
// Functional notes
// - Row strobe stays low between column accesses.
// - Column strobe follows each column access immediately.
// - Precharge follows both strobes returning high.
// - Row-only refresh keeps column strobe high.
// - One glue block drives three strobes.
// - Row window sets, end window clears row.
// - Column window drives column strobe low.
// - Write strobe is write delayed one clock.
`timescale 1ns/1ps
`default_nettype none
module ddg_glue (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire ddg_pkg::ddg_bus_s bus_in,
  output ddg_pkg::ddg_dram_s dram_out,
  output logic ras_overlong_out
);
  ddg_pkg::ddg_bus_s sync1_reg;
  ddg_pkg::ddg_bus_s sync2_reg;
  logic ras_n_reg;
  logic write_n_reg;
  logic row_hit;
  logic end_hit;
  logic col_hit;
  logic [21:0] ras_cnt_reg;

  // Two-stage synchroniser for the asynchronous DSP bus pins.
  always_ff @(posedge core_clk_in) begin
    sync1_reg <= bus_in;
    sync2_reg <= sync1_reg;
  end

  // True when the select is active and the top address bits pick a window.
  function automatic logic sel_hit(input ddg_pkg::ddg_bus_s b,
    input logic [1:0] sel);
    return !b.data_memory_select_n &&
      b.addr[ddg_pkg::SEL_HI:ddg_pkg::SEL_LO] == sel;
  endfunction : sel_hit

  // Address window decode.
  always_comb begin
    row_hit = sel_hit(sync2_reg, ddg_pkg::ROW_SEL) && !sync2_reg.rd_n &&
      sync2_reg.addr[ddg_pkg::SUB_BIT_HI:ddg_pkg::SUB_BIT_LO] ==
      ddg_pkg::SUB_LOW_WIN;
    end_hit = sel_hit(sync2_reg, ddg_pkg::ROW_END_SEL) && !sync2_reg.rd_n &&
      sync2_reg.addr[ddg_pkg::ROW_END_SUB_BIT] == ddg_pkg::ROW_END_SUB;
    col_hit = sel_hit(sync2_reg, ddg_pkg::COL_SEL) &&
      (!sync2_reg.rd_n || !sync2_reg.wr_n) &&
      sync2_reg.addr[ddg_pkg::SUB_BIT_HI:ddg_pkg::SUB_BIT_LO] ==
      ddg_pkg::SUB_LOW_WIN;
  end

  // Row strobe set/clear latch; holds between column accesses.
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      ras_n_reg <= 1'h1;
    end else if (row_hit) begin
      ras_n_reg <= 1'h0;
    end else if (end_hit) begin
      ras_n_reg <= 1'h1;
    end
  end

  // Write strobe delayed by one clock.
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      write_n_reg <= 1'h1;
    end else begin
      write_n_reg <= sync2_reg.wr_n;
    end
  end

  // Row strobe low-time monitor, saturating.
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in || ras_n_reg) begin
      ras_cnt_reg <= 22'h0;
    end else if (ras_cnt_reg != 22'(ddg_pkg::MAX_RAS_CYC)) begin
      ras_cnt_reg <= ras_cnt_reg + 22'h1;
    end
  end

  assign dram_out.ras_n = ras_n_reg;
  assign dram_out.cas_n = !col_hit;
  assign dram_out.write_n = write_n_reg;
  assign ras_overlong_out = ras_cnt_reg == 22'(ddg_pkg::MAX_RAS_CYC);

  // Named steps of the row strobe and write strobe responses.
  sequence s_ras_low_next;
    ##1 !dram_out.ras_n;
  endsequence

  sequence s_ras_high_next;
    ##1 dram_out.ras_n;
  endsequence

  sequence s_write_low_next;
    ##1 !dram_out.write_n;
  endsequence

  // Row strobe checks.
  a_ras_falls_row: assert property (@(posedge core_clk_in)
    disable iff (!resetn_in) row_hit |=> !dram_out.ras_n)
    else $error("row strobe did not fall");

  a_ras_rises_end: assert property (@(posedge core_clk_in)
    disable iff (!resetn_in) (end_hit && !row_hit) |=> dram_out.ras_n)
    else $error("row strobe did not rise");

  a_ras_holds: assert property (@(posedge core_clk_in)
    disable iff (!resetn_in) (!row_hit && !end_hit) |=>
    dram_out.ras_n == $past(dram_out.ras_n))
    else $error("row strobe changed without cause");

  a_row_opens: assert property (@(posedge core_clk_in)
    disable iff (!resetn_in) row_hit |-> s_ras_low_next)
    else $error("row strobe did not open the row");

  a_row_shuts: assert property (@(posedge core_clk_in)
    disable iff (!resetn_in) (end_hit && !row_hit) |-> s_ras_high_next)
    else $error("row strobe did not close the row");

  a_page_stays_open: assert property (@(posedge core_clk_in)
    disable iff (!resetn_in) (!dram_out.ras_n && !end_hit) |=> !dram_out.ras_n)
    else $error("row strobe left the page early");

  a_precharge_high: assert property (@(posedge core_clk_in)
    disable iff (!resetn_in) (dram_out.ras_n && !row_hit) |=> dram_out.ras_n)
    else $error("row strobe fell during precharge");

  a_reset_ras_high: assert property (@(posedge core_clk_in)
    !resetn_in |=> dram_out.ras_n)
    else $error("row strobe low after reset");

  // Column strobe checks.
  a_cas_window: assert property (@(posedge core_clk_in)
    disable iff (!resetn_in) !dram_out.cas_n |->
    !sync2_reg.data_memory_select_n)
    else $error("column strobe low without select");

  a_refresh_no_cas: assert property (@(posedge core_clk_in)
    disable iff (!resetn_in) (row_hit || end_hit) |-> dram_out.cas_n)
    else $error("column strobe low during row cycle");

  a_end_no_cas: assert property (@(posedge core_clk_in)
    disable iff (!resetn_in) end_hit |-> dram_out.cas_n)
    else $error("column strobe low on row close");

  a_cas_follows_hit: assert property (@(posedge core_clk_in)
    disable iff (!resetn_in) col_hit |-> !dram_out.cas_n)
    else $error("column strobe late for column access");

  a_cas_idle_high: assert property (@(posedge core_clk_in)
    disable iff (!resetn_in) !col_hit |-> dram_out.cas_n)
    else $error("column strobe low outside its window");

  a_cas_needs_strobe: assert property (@(posedge core_clk_in)
    disable iff (!resetn_in) !dram_out.cas_n |->
    (!sync2_reg.rd_n || !sync2_reg.wr_n))
    else $error("column strobe low without read or write");

  a_cas_col_window: assert property (@(posedge core_clk_in)
    disable iff (!resetn_in) !dram_out.cas_n |->
    sync2_reg.addr[ddg_pkg::SEL_HI:ddg_pkg::SEL_LO] == ddg_pkg::COL_SEL)
    else $error("column strobe low for wrong window");

  // Write strobe checks.
  a_write_delay: assert property (@(posedge core_clk_in)
    disable iff (!resetn_in) 1'b1 |=>
    dram_out.write_n == $past(sync2_reg.wr_n))
    else $error("write strobe not delayed one clock");

  a_write_follows: assert property (@(posedge core_clk_in)
    disable iff (!resetn_in) !sync2_reg.wr_n |-> s_write_low_next)
    else $error("write strobe did not follow write");

  a_write_high_idle: assert property (@(posedge core_clk_in)
    disable iff (!resetn_in) sync2_reg.wr_n |=> dram_out.write_n)
    else $error("write strobe low without write");

  a_refresh_write_high: assert property (@(posedge core_clk_in)
    disable iff (!resetn_in) (row_hit || end_hit) |=> dram_out.write_n)
    else $error("write strobe low during row cycle");

  a_reset_write_high: assert property (@(posedge core_clk_in)
    !resetn_in |=> dram_out.write_n)
    else $error("write strobe low after reset");

  // Row strobe low-time monitor checks.
  a_ras_limit_flag: assert property (@(posedge core_clk_in)
    disable iff (!resetn_in) dram_out.ras_n |=> !ras_overlong_out)
    else $error("overlong flag with row strobe high");

  a_count_clear: assert property (@(posedge core_clk_in)
    disable iff (!resetn_in) dram_out.ras_n |=> ras_cnt_reg == 22'h0)
    else $error("low-time count not cleared");

  a_overlong_sets: assert property (@(posedge core_clk_in)
    disable iff (!resetn_in) (!dram_out.ras_n &&
    ras_cnt_reg == 22'(ddg_pkg::MAX_RAS_CYC - 1)) |=> ras_overlong_out)
    else $error("overlong flag did not set");

  a_overlong_holds: assert property (@(posedge core_clk_in)
    disable iff (!resetn_in) (!dram_out.ras_n && ras_overlong_out) |=> ras_overlong_out)
    else $error("overlong flag dropped while row strobe low");

  a_count_steps: assert property (@(posedge core_clk_in)
    disable iff (!resetn_in) (!dram_out.ras_n && !ras_overlong_out) |=>
    ras_cnt_reg == $past(ras_cnt_reg) + 22'h1)
    else $error("low-time count did not step");

  a_reset_flag_clear: assert property (@(posedge core_clk_in)
    !resetn_in |=> !ras_overlong_out)
    else $error("overlong flag set after reset");
endmodule : ddg_glue
`default_nettype wire

/* ddg_glue_tb.sv */
// Purpose: Self-checking bench for the DRAM glue block.
// Assumes: Strobe changes land on distinct clock edges.
// Notes: Expected strobe states are queued in order.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; \
  $display("mismatch %0t got %b want %b", $time, a, b); end end
module ddg_glue_tb;
  logic core_clk_in = 0;
  logic resetn_in = 0;
  ddg_pkg::ddg_bus_s bus;
  ddg_pkg::ddg_dram_s dram_out, last, exp, want;
  logic ras_overlong;
  ddg_pkg::ddg_dram_s notes[$];
  int num_errors = 0, compares = 0, seed = 11, n;
  ddg_dsp_model dsp (.core_clk_in(core_clk_in), .bus_out(bus));
  ddg_glue dut (.core_clk_in(core_clk_in), .resetn_in(resetn_in),
    .bus_in(bus), .dram_out(dram_out), .ras_overlong_out(ras_overlong));
  initial forever #50 core_clk_in = ~core_clk_in;
  task automatic note(input logic [2:0] v);
    exp = v;
    notes.push_back(exp);
  endtask : note
  task automatic go(input logic [13:0] a, input logic wr);
    if (a[13:10] == 4'h4 && exp.ras_n) note(3'b011);
    if (a[13:11] == 3'b100 && !exp.ras_n) note(3'b111);
    if (a[13:10] == 4'hc) begin
      note({exp.ras_n, 2'b01});
      if (wr) note({exp.ras_n, 2'b00});
      note({exp.ras_n, 1'b1, ~wr});
      if (wr) note({exp.ras_n, 2'b11});
    end
    dsp.access(a, wr);
  endtask : go
  // One timer interrupt's worth of row-only refresh.
  task automatic refresh_bank(input logic [1:0] bank);
    for (int r = 0; r < 256; r++) begin
      go({4'h4, bank, 8'(r)}, 1'b0);
      go(14'h2000, 1'b0);
    end
  endtask : refresh_bank
  always @(posedge core_clk_in) begin
    #5;
    if (resetn_in && dram_out !== last) begin
      last = dram_out;
      want = notes.size() ? notes.pop_front() : 'x;
      `CHK(dram_out, want)
    end
  end
  task automatic end_of_test;
    $display("num_errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_of_test
  initial begin
    #3000000;
    num_errors++;
    end_of_test();
  end
  initial begin
    exp = '1;
    last = '1;
    repeat (3) @(posedge core_clk_in);
    #1 resetn_in = 1;
    go(14'h2000, 1'b0);
    repeat (16) begin
      go({4'h4, 10'($random(seed))}, 1'b0);
      go(14'h0abc, 1'b0);
      n = $unsigned($random(seed)) % 4;
      repeat (n) go({4'hc, 10'($random(seed))}, 1'($random(seed)));
      go({3'b100, 11'($random(seed))}, 1'b0);
    end
    for (int b = 0; b < 4; b++) begin
      refresh_bank(2'(b));
      go({4'h4, 10'($random(seed))}, 1'b0);
      go({4'hc, 10'($random(seed))}, 1'($random(seed)));
      go(14'h2000, 1'b0);
    end
    go(14'h1000, 1'b0);
    repeat (ddg_pkg::MAX_RAS_CYC - 10) @(posedge core_clk_in);
    #5 `CHK(ras_overlong, 1'b0)
    repeat (20) @(posedge core_clk_in);
    #5 `CHK(ras_overlong, 1'b1)
    go(14'h2000, 1'b0);
    #5 `CHK(ras_overlong, 1'b0)
    repeat (5) @(posedge core_clk_in);
    `CHK(notes.size(), 0)
    end_of_test();
  end
endmodule : ddg_glue_tb
`default_nettype wire

/* ddg_pkg.sv */
// Purpose: Shared constants and types for the DSP to DRAM glue block.
// Assumes: Fourteen-bit DSP address bus, active-low strobes.
// Notes: Address windows are decoded from the top address bits.
package ddg_pkg;
  localparam int ADDR_W = 14;
  localparam logic [1:0] ROW_SEL = 2'h1;
  localparam logic [1:0] ROW_END_SEL = 2'h2;
  localparam logic [1:0] COL_SEL = 2'h3;
  localparam int SEL_HI = 13;
  localparam int SEL_LO = 12;
  localparam int SUB_BIT_HI = 11;
  localparam int SUB_BIT_LO = 10;
  localparam logic [1:0] SUB_LOW_WIN = 2'h0;
  localparam logic ROW_END_SUB = 1'h0;
  localparam int ROW_END_SUB_BIT = 11;
  localparam int CLK_NS = 100;
  localparam int MAX_RAS_US = 200;
  localparam int MAX_RAS_CYC = (MAX_RAS_US * 1000) / CLK_NS;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic data_memory_select_n;
    logic rd_n;
    logic wr_n;
  } ddg_bus_s;

  typedef struct packed {
    logic ras_n;
    logic cas_n;
    logic write_n;
  } ddg_dram_s;
endpackage : ddg_pkg
